// *** rtl/sfp_defs.svh ***
// constants of the serial flash pin front end
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH
`define SFP_CMD_READ 8'h03
`define SFP_CMD_READ2 8'h3B
`define SFP_CMD_READ4 8'h6B
`define SFP_CMD_PROG 8'h02
`define SFP_CMD_ER4K 8'h20
`define SFP_CMD_ER32K 8'h52
`define SFP_CMD_ER64K 8'hD8
`define SFP_CMD_ERCHIP 8'hC7
`define SFP_ADDR_LAST 5'd23
`define SFP_DUMMY_LAST 4'd7
`define SFP_PAGE_BYTES 9'h100
`define SFP_PAGE_COUNT 17'h10000
`define SFP_MASK4K 24'hFFF000
`define SFP_MASK32K 24'hFF8000
`define SFP_MASK64K 24'hFF0000
`define SFP_IDLE_BYTE 8'hFF
`define SFP_FIFO_DEPTH 4
`define SFP_RST_IO 4'hF
`endif

// *** rtl/sfp_pkg.sv ***
// types of the serial flash pin front end
package sfp_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMD = 6'h02,
    ST_ADDR = 6'h04,
    ST_DUMMY = 6'h08,
    ST_READ = 6'h10,
    ST_DONE = 6'h20
  } sfp_state_t;
  typedef enum logic [2:0] {
    LN_ONE = 3'h1,
    LN_TWO = 3'h2,
    LN_FOUR = 3'h4
  } sfp_lanes_t;
  typedef enum logic [3:0] {
    ER_NONE = 4'h0,
    ER_4K = 4'h1,
    ER_32K = 4'h2,
    ER_64K = 4'h4,
    ER_CHIP = 4'h8
  } sfp_erase_t;
endpackage

// *** rtl/sfp_fifo.sv ***
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// *** rtl/sfp_pin_if.sv ***
// serial flash pin front end: select, clock edges, lanes, protect, pause
`timescale 1ns/100ps
`include "sfp_defs.svh"
module sfp_pin_if
  import sfp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  input wire logic quad_enable_bit,
  input wire logic status_lock_bit,
  input wire logic small_region_select,
  input wire logic top_bottom_select,
  input wire logic block_protect_hi,
  input wire logic block_protect_mid,
  input wire logic block_protect_lo,
  input wire logic array_busy,
  output logic standby_mode,
  output logic active_mode,
  output logic sr_write_ok,
  output logic array_locked,
  output logic [4:0] protect_cfg,
  output logic paused,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic rd_ready,
  output logic rd_underrun,
  output logic pgm_valid,
  output logic [7:0] pgm_data,
  output logic [23:0] pgm_addr,
  output logic erase_req,
  output sfp_erase_t erase_kind,
  output logic [23:0] erase_addr
);
  logic cs_m, cs_s, cs_d;
  logic sck_m, sck_s, sck_d;
  logic [3:0] io_m, io_s;
  logic hold_d;
  logic cs_fall, cs_rise, sck_rise, sck_fall;
  logic hold_fall, hold_rise, hw_lock;
  sfp_state_t state;
  sfp_lanes_t lanes;
  sfp_erase_t er_kind;
  logic [2:0] bitc;
  logic [4:0] abit;
  logic [3:0] dcnt;
  logic [7:0] in_sh;
  logic [7:0] next_byte;
  logic [23:0] addr;
  logic is_prog, er_pend;
  logic [8:0] prog_cnt;
  logic [7:0] osh;
  logic [3:0] obits;
  logic [7:0] cur;
  logic [3:0] nb;
  logic pop;
  logic [7:0] f_data;
  logic f_valid;

  // two-flop synchronisers for every pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      io_m <= `SFP_RST_IO;
      io_s <= `SFP_RST_IO;
      hold_d <= 1'b1;
    end else begin
      cs_m <= cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
      sck_m <= sck;
      sck_s <= sck_m;
      sck_d <= sck_s;
      io_m <= io_in;
      io_s <= io_m;
      hold_d <= io_s[3];
    end
  end

  assign cs_fall = cs_d && !cs_s;
  assign cs_rise = !cs_d && cs_s;
  // edges count only while selected and not paused; idle level is free
  assign sck_rise = sck_s && !sck_d && !cs_s && !paused;
  assign sck_fall = !sck_s && sck_d && !cs_s && !paused;
  // hold shares lane 3, usable only while quad lanes are off
  assign hold_fall = !quad_enable_bit && hold_d && !io_s[3];
  assign hold_rise = !quad_enable_bit && !hold_d && io_s[3];

  assign active_mode = !cs_s;
  assign standby_mode = cs_s && !array_busy;
  // write-protect pin on lane 2 is only meaningful without quad lanes
  assign hw_lock = !quad_enable_bit && !io_s[2] && status_lock_bit;
  assign sr_write_ok = !hw_lock;
  assign array_locked = hw_lock && (block_protect_hi || block_protect_mid || block_protect_lo);
  assign protect_cfg = hw_lock ? {small_region_select, top_bottom_select, block_protect_hi,
                                  block_protect_mid, block_protect_lo} : 5'h00;

  always_ff @(posedge core_clk) begin
    if (rst || cs_s) begin
      paused <= 1'b0;
    end else if (!paused && hold_fall && !sck_s) begin
      paused <= 1'b1;
    end else if (paused && hold_rise && !sck_s) begin
      paused <= 1'b0;
    end
  end

  assign next_byte = {in_sh[6:0], io_s[0]};

  // command, address and program capture on rising edges
  always_ff @(posedge core_clk) begin
    pgm_valid <= 1'b0;
    erase_req <= 1'b0;
    if (rst) begin
      state <= ST_IDLE;
      lanes <= LN_ONE;
      er_kind <= ER_NONE;
      bitc <= 3'h0;
      abit <= 5'h00;
      dcnt <= 4'h0;
      in_sh <= 8'h00;
      addr <= 24'h000000;
      is_prog <= 1'b0;
      er_pend <= 1'b0;
      prog_cnt <= 9'h000;
      pgm_data <= 8'h00;
      pgm_addr <= 24'h000000;
      erase_kind <= ER_NONE;
      erase_addr <= 24'h000000;
    end else if (cs_s) begin
      // deselect ends any frame; an armed erase starts at the rising select unless paused or the array is locked
      if (cs_rise && er_pend && !paused && !array_locked) begin
        erase_req <= 1'b1;
        erase_kind <= er_kind;
        unique case (er_kind)
          ER_4K: erase_addr <= addr & `SFP_MASK4K;
          ER_32K: erase_addr <= addr & `SFP_MASK32K;
          ER_64K: erase_addr <= addr & `SFP_MASK64K;
          default: erase_addr <= 24'h000000;
        endcase
      end
      state <= ST_IDLE;
      er_pend <= 1'b0;
    end else if (cs_fall) begin
      state <= ST_CMD;
      bitc <= 3'h0;
      abit <= 5'h00;
      dcnt <= 4'h0;
      prog_cnt <= 9'h000;
      is_prog <= 1'b0;
      er_kind <= ER_NONE;
    end else if (sck_rise) begin
      unique case (state)
        ST_IDLE, ST_READ, ST_DONE: begin
        end
        ST_CMD: begin
          in_sh <= next_byte;
          bitc <= bitc + 3'h1;
          if (bitc == 3'h7) begin
            state <= ST_ADDR;
            lanes <= LN_ONE;
            unique case (next_byte)
              `SFP_CMD_READ: lanes <= LN_ONE;
              `SFP_CMD_READ2: lanes <= LN_TWO;
              `SFP_CMD_READ4: lanes <= LN_FOUR;
              `SFP_CMD_PROG: is_prog <= 1'b1;
              `SFP_CMD_ER4K: er_kind <= ER_4K;
              `SFP_CMD_ER32K: er_kind <= ER_32K;
              `SFP_CMD_ER64K: er_kind <= ER_64K;
              `SFP_CMD_ERCHIP: begin
                er_kind <= ER_CHIP;
                er_pend <= 1'b1;
                state <= ST_DONE;
              end
              default: state <= ST_DONE;
            endcase
          end
        end
        ST_ADDR: begin
          addr <= {addr[22:0], io_s[0]};
          abit <= abit + 5'h01;
          if (abit == `SFP_ADDR_LAST) begin
            if (is_prog) begin
              state <= ST_DONE;
            end else if (er_kind != ER_NONE) begin
              er_pend <= 1'b1;
              state <= ST_DONE;
            end else if (lanes == LN_ONE) begin
              state <= ST_READ;
            end else begin
              state <= ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          dcnt <= dcnt + 4'h1;
          if (dcnt == `SFP_DUMMY_LAST) begin
            state <= ST_READ;
          end
        end
      endcase
      // program data after the address, capped at one page
      if (state == ST_DONE && is_prog) begin
        in_sh <= next_byte;
        bitc <= bitc + 3'h1;
        if (bitc == 3'h7 && prog_cnt != `SFP_PAGE_BYTES && !array_locked) begin
          pgm_valid <= 1'b1;
          pgm_data <= next_byte;
          pgm_addr <= {addr[23:8], addr[7:0] + prog_cnt[7:0]};
          prog_cnt <= prog_cnt + 9'h001;
        end
      end
    end
  end

  // read byte source
  sfp_fifo #(
    .WIDTH(8),
    .DEPTH(`SFP_FIFO_DEPTH)
  ) u_rd_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(rd_data),
    .in_valid(rd_valid),
    .in_ready(rd_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(pop)
  );

  assign pop = sck_fall && state == ST_READ && obits == 4'h0;
  assign cur = (obits != 4'h0) ? osh : (f_valid ? f_data : `SFP_IDLE_BYTE);
  assign nb = (lanes == LN_FOUR) ? 4'h4 : ((lanes == LN_TWO) ? 4'h2 : 4'h1);

  // read data shifts out on falling edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      io_out <= 4'h0;
      osh <= 8'h00;
      obits <= 4'h0;
    end else if (cs_fall) begin
      obits <= 4'h0;
    end else if (sck_fall && state == ST_READ) begin
      obits <= ((obits == 4'h0) ? 4'h8 : obits) - nb;
      unique case (lanes)
        LN_ONE: begin
          io_out <= {2'b00, cur[7], 1'b0};
          osh <= {cur[6:0], 1'b0};
        end
        LN_TWO: begin
          io_out <= {2'b00, cur[7:6]};
          osh <= {cur[5:0], 2'b00};
        end
        LN_FOUR: begin
          io_out <= cur[7:4];
          osh <= {cur[3:0], 4'h0};
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || cs_fall) begin
      rd_underrun <= 1'b0;
    end else if (pop && !f_valid) begin
      rd_underrun <= 1'b1;
    end
  end

  always_comb begin
    io_oe_n = 4'hF;
    if (!cs_s && !paused && state == ST_READ) begin
      unique case (lanes)
        LN_ONE: io_oe_n = 4'hD;
        LN_TWO: io_oe_n = 4'hC;
        LN_FOUR: io_oe_n = 4'h0;
      endcase
    end
  end

  AST_DESEL_HIZ: assert property (@(posedge core_clk) disable iff (rst)
    cs_s |-> io_oe_n == 4'hF) else $error("lines driven while deselected");
  AST_STANDBY: assert property (@(posedge core_clk) disable iff (rst)
    standby_mode |-> cs_s && !array_busy) else $error("standby while selected or busy");
  AST_ACTIVE: assert property (@(posedge core_clk) disable iff (rst)
    $fell(cs_s) |-> active_mode && !standby_mode) else $error("select low not active");
  AST_RISE_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
    $changed(addr) |-> $past(sck_s) && !$past(sck_d)) else $error("address moved off rise");
  AST_FALL_OUT: assert property (@(posedge core_clk) disable iff (rst)
    $changed(io_out) |-> !$past(sck_s) && $past(sck_d)) else $error("output moved off fall");
  AST_QUAD_OE: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_READ && lanes == LN_FOUR && !cs_s && !paused |-> io_oe_n == 4'h0)
    else $error("quad read lanes not driven");
  AST_DESEL_IGNORE: assert property (@(posedge core_clk) disable iff (rst)
    cs_s && $past(cs_s) |=> $stable(in_sh) && $stable(addr)) else $error("input taken deselected");
  AST_DUAL_OE: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_READ && lanes == LN_TWO && !cs_s && !paused |-> io_oe_n == 4'hC)
    else $error("dual read lanes wrong");
  AST_WP_QUAD: assert property (@(posedge core_clk) disable iff (rst)
    quad_enable_bit |-> sr_write_ok && !array_locked) else $error("protect with quad lanes");
  AST_WP_LOW: assert property (@(posedge core_clk) disable iff (rst)
    !sr_write_ok |-> !io_s[2] && status_lock_bit) else $error("lock without pin low");
  AST_PAGE_CAP: assert property (@(posedge core_clk) disable iff (rst)
    pgm_valid |-> prog_cnt <= `SFP_PAGE_BYTES && pgm_addr[23:8] == addr[23:8])
    else $error("program ran past page");
  AST_ERASE_ALIGN: assert property (@(posedge core_clk) disable iff (rst)
    erase_req && erase_kind == ER_4K |-> erase_addr[11:0] == 12'h000) else $error("unaligned");
  AST_PAUSE_ENTER: assert property (@(posedge core_clk) disable iff (rst)
    $rose(paused) |-> !$past(sck_s) && !$past(io_s[3]) && $past(hold_d))
    else $error("pause entered wrongly");
  AST_PAUSE_RESET: assert property (@(posedge core_clk) disable iff (rst)
    paused && cs_s |=> !paused && state == ST_IDLE && !erase_req) else $error("no reset in pause");

  COV_QUAD_READ: cover property (@(posedge core_clk) disable iff (rst)
    pop && lanes == LN_FOUR);
  COV_PROGRAM: cover property (@(posedge core_clk) disable iff (rst) pgm_valid);
  COV_ERASE: cover property (@(posedge core_clk) disable iff (rst) erase_req);
  COV_PAUSE: cover property (@(posedge core_clk) disable iff (rst) $fell(paused) && !cs_s);
endmodule

// *** tb/sfp_host_model.sv ***
// host flash controller model: select, serial clock and lane drive
`timescale 1ns/100ps
module sfp_host_model (
  output logic cs_n,
  output logic sck,
  output logic [3:0] h_out,
  output logic [3:0] h_oe,
  input wire logic [3:0] io_in,
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  localparam realtime HALF = 100.0;
  // clock level between frames: low for mode 0, high for mode 3
  logic idle_lvl = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    h_out = 4'hC;
    h_oe = 4'hC;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
  end
  // odd offset keeps the link clock out of step with the core clock
  task automatic start();
    #13.7 cs_n = 1'b0;
    #HALF sck = 1'b0;
  endtask
  task automatic idle(input logic v);
    idle_lvl = v;
    sck = v;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      h_oe[0] = 1'b1;
      h_out[0] = b[i];
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
    end
  endtask
  task automatic ticks(input int n);
    h_oe[0] = 1'b0;
    repeat (n) begin
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
    end
  endtask
  // slow master: samples at the end of the high phase
  task automatic recv(input int lanes);
    logic [7:0] b;
    h_oe = (lanes == 4) ? 4'h0 : 4'hC;
    for (int i = 0; i < 8; i += lanes) begin
      #HALF sck = 1'b1;
      #HALF;
      if (lanes == 1) b = {b[6:0], io_in[1]};
      else if (lanes == 2) b = {b[5:0], io_in[1:0]};
      else b = {b[3:0], io_in};
      sck = 1'b0;
    end
    rx_byte = b;
    rx_stb = 1'b1;
    #1 rx_stb = 1'b0;
  endtask
  // wp and hold levels only move while the clock is low
  task automatic pin(input int i, input logic v);
    #(HALF / 2) h_out[i] = v;
    #(1.5 * HALF);
  endtask
  task automatic stop();
    #HALF cs_n = 1'b1;
    sck = idle_lvl;
    h_oe = 4'hC;
    #(2 * HALF);
  endtask
endmodule

// *** tb/sfp_pin_if_test.sv ***
// self-checking bench of the serial flash pin front end
`timescale 1ns/100ps
module sfp_pin_if_test;
  import sfp_pkg::*;
  localparam logic [7:0] ER_CODE [4] = '{8'h20, 8'h52, 8'hD8, 8'hC7};
  localparam int ER_SHIFT [4] = '{12, 15, 16, 24};
  localparam sfp_erase_t ER_KIND [4] = '{ER_4K, ER_32K, ER_64K, ER_CHIP};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sck, array_busy, rd_valid, rd_ready, rd_underrun, rx_stb;
  logic quad_enable_bit, status_lock_bit, small_region_select, top_bottom_select;
  logic block_protect_hi, block_protect_mid, block_protect_lo;
  logic standby_mode, active_mode, sr_write_ok, array_locked, paused, pgm_valid, erase_req;
  logic [1:0] pat = 2'b01;
  logic [3:0] io_in, io_out, io_oe_n, h_out, h_oe;
  logic [4:0] protect_cfg;
  logic [7:0] rd_data, pgm_data, rx_byte, b;
  logic [23:0] pgm_addr, erase_addr, a;
  sfp_erase_t erase_kind;
  logic [39:0] exp_q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  sfp_pin_if i_sfp_pin_if (.core_clk, .rst, .cs_n, .sck, .io_in, .io_out, .io_oe_n,
    .quad_enable_bit, .status_lock_bit, .small_region_select, .top_bottom_select,
    .block_protect_hi, .block_protect_mid, .block_protect_lo, .array_busy, .standby_mode,
    .active_mode, .sr_write_ok, .array_locked, .protect_cfg, .paused, .rd_data, .rd_valid,
    .rd_ready, .rd_underrun, .pgm_valid, .pgm_data, .pgm_addr, .erase_req, .erase_kind,
    .erase_addr);
  sfp_host_model i_sfp_host_model (.cs_n, .sck, .h_out, .h_oe, .io_in, .rx_byte, .rx_stb);
  initial forever #12.5 core_clk = ~core_clk;
  // released lanes 0 and 1 never keep their last level; released lanes 2 and 3 read high
  always @(posedge core_clk) pat <= ~pat;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (h_oe[i]) io_in[i] = h_out[i];
      else if (io_oe_n[i] === 1'b0) io_in[i] = io_out[i];
      else io_in[i] = (i > 1) ? 1'b1 : pat[i % 2];
    end
  end
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic take(input logic [39:0] got);
    if (exp_q.size() == 0) check(got, 40'hX);
    else check(got, exp_q.pop_front());
  endtask
  always @(posedge rx_stb) take({8'h01, 24'h0, rx_byte});
  always @(negedge core_clk) begin
    if (pgm_valid === 1'b1) take({8'h02, pgm_addr, pgm_data});
    if (erase_req === 1'b1)
      take({4'h3, erase_kind, erase_kind == ER_CHIP ? 24'h0 : erase_addr, 8'h00});
  end
  task automatic push(input logic [7:0] v);
    @(negedge core_clk);
    rd_data = v;
    rd_valid = 1'b1;
    exp_q.push_back({8'h01, 24'h0, v});
  endtask
  task automatic cmd(input logic [7:0] c, input logic [23:0] ad, input int n = 3);
    i_sfp_host_model.start();
    i_sfp_host_model.send(c);
    for (int i = n - 1; i >= 0; i--) i_sfp_host_model.send(ad[8*i +: 8]);
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    conclude();
  end
  initial begin
    array_busy = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
    {quad_enable_bit, status_lock_bit, small_region_select, top_bottom_select} = 4'h8;
    {block_protect_hi, block_protect_mid, block_protect_lo} = 3'h0;
    void'($urandom(32'h25DA));
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check(io_oe_n, 4'hF);
    check(standby_mode, 1'b1);
    array_busy = 1'b1;
    @(negedge core_clk);
    check(standby_mode, 1'b0);
    array_busy = 1'b0;
    quad_enable_bit = 1'b0;
    repeat (4) push(8'($urandom));
    @(negedge core_clk);
    rd_data = 8'($urandom);
    @(negedge core_clk);
    check(rd_ready, 1'b0);
    rd_valid = 1'b0;
    cmd(8'h03, 24'($urandom));
    check(active_mode, 1'b1);
    check(standby_mode, 1'b0);
    repeat (2) i_sfp_host_model.recv(1);
    i_sfp_host_model.pin(3, 1'b0);
    check(paused, 1'b1);
    i_sfp_host_model.ticks(8);
    i_sfp_host_model.pin(3, 1'b1);
    check(paused, 1'b0);
    exp_q.push_back({8'h01, 24'h0, 8'hFF});
    repeat (3) i_sfp_host_model.recv(1);
    check(io_oe_n, 4'hD);
    check(rd_underrun, 1'b1);
    i_sfp_host_model.stop();
    check(io_oe_n, 4'hF);
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk);
      quad_enable_bit = 1'b1;
      repeat (2) push(8'($urandom));
      @(negedge core_clk);
      rd_valid = 1'b0;
      cmd(k ? 8'h6B : 8'h3B, 24'($urandom));
      i_sfp_host_model.ticks(8);
      repeat (2) i_sfp_host_model.recv(k ? 4 : 2);
      check(io_oe_n, k ? 4'h0 : 4'hC);
      i_sfp_host_model.stop();
    end
    i_sfp_host_model.idle(1'b1);
    a = {16'($urandom), 8'hFE};
    cmd(8'h02, a);
    for (int i = 0; i < 257; i++) begin
      b = 8'($urandom);
      if (i < 256) exp_q.push_back({8'h02, a[23:8], 8'(a[7:0] + i), b});
      i_sfp_host_model.send(b);
    end
    i_sfp_host_model.ticks(4);
    i_sfp_host_model.stop();
    for (int k = 0; k < 4; k++) begin
      a = 24'($urandom);
      exp_q.push_back({4'h3, ER_KIND[k], (a >> ER_SHIFT[k]) << ER_SHIFT[k], 8'h00});
      cmd(ER_CODE[k], a, k < 3 ? 3 : 0);
      i_sfp_host_model.stop();
    end
    i_sfp_host_model.idle(1'b0);
    @(negedge core_clk);
    quad_enable_bit = 1'b0;
    status_lock_bit = 1'b1;
    {small_region_select, top_bottom_select, block_protect_hi, block_protect_mid} = 4'($urandom);
    block_protect_lo = 1'b1;
    i_sfp_host_model.pin(2, 1'b0);
    check(array_locked, 1'b1);
    check(sr_write_ok, 1'b0);
    check(protect_cfg, {small_region_select, top_bottom_select, block_protect_hi,
      block_protect_mid, block_protect_lo});
    cmd(8'h02, 24'($urandom));
    i_sfp_host_model.send(8'($urandom));
    i_sfp_host_model.stop();
    @(negedge core_clk);
    quad_enable_bit = 1'b1;
    repeat (4) @(negedge core_clk);
    check(array_locked, 1'b0);
    check(sr_write_ok, 1'b1);
    quad_enable_bit = 1'b0;
    i_sfp_host_model.pin(2, 1'b1);
    cmd(8'h20, 24'($urandom));
    i_sfp_host_model.pin(3, 1'b0);
    check(paused, 1'b1);
    i_sfp_host_model.stop();
    i_sfp_host_model.pin(3, 1'b1);
    check(paused, 1'b0);
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge core_clk);
    if (exp_q.size() > 0) n_mismatch++;
    conclude();
  end
endmodule
